// ---- hw/sensor_tp_pkg.sv ----
/*
 * Constants for the test-pattern and calibration-status register bank:
 * register indices, field positions, reset values and bus codes.
 * Assumes an AXI4-Lite slave with byte address = 4 * register index.
 */
package sensor_tp_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_FAULT     = 8'h88;
   localparam logic [7:0]  IDX_RSV_A     = 8'h89;
   localparam logic [7:0]  IDX_RSV_B     = 8'h8a;
   localparam logic [7:0]  IDX_RSV_C     = 8'h8b;
   localparam logic [7:0]  IDX_CFG_A     = 8'h8c;
   localparam logic [7:0]  IDX_CFG_B     = 8'h8d;
   localparam logic [7:0]  IDX_CTRL      = 8'h90;
   localparam logic [7:0]  IDX_CFG_C     = 8'h91;
   localparam logic [7:0]  IDX_LOW01     = 8'h92;
   localparam logic [7:0]  IDX_LOW23     = 8'h93;
   localparam logic [7:0]  IDX_CFG_D     = 8'h94;
   localparam logic [7:0]  IDX_HIGH      = 8'h96;
   localparam logic [7:0]  IDX_SAMPLES   = 8'h9b;
   localparam logic [7:0]  IDX_STATUS    = 8'h9c;
   localparam logic [7:0]  IDX_CLEAR     = 8'h9d;
   localparam logic [7:0]  IDX_ENABLE    = 8'h9e;
   localparam int          ADDR_WIDTH    = 10;
   localparam int          IDX_LSB       = 2;
   // pattern control fields
   localparam int          CTRL_TP_EN    = 0;
   localparam int          CTRL_INC      = 1;
   localparam int          CTRL_PRBS     = 2;
   localparam int          CTRL_FRAMED   = 3;
   // sample-count field position in its register
   localparam int          SAMPLES_LSB   = 8;
   // reset values
   localparam logic [3:0]  CTRL_RESET    = 4'h0;
   localparam logic [15:0] LOW01_RESET   = 16'h0100;
   localparam logic [15:0] LOW23_RESET   = 16'h0302;
   localparam logic [7:0]  HIGH_RESET    = 8'h00;
   localparam logic [7:0]  FAULT_RESET   = 8'h00;
   localparam logic [2:0]  SAMPLES_RESET = 3'h0;
   localparam logic [15:0] CFG_B_VALUE   = 16'hffff;
   localparam logic [15:0] CFG_D_VALUE   = 16'h0504;
   localparam logic [9:0]  PRBS_SEED     = 10'h3ff;
   // geometry
   localparam int          LANES         = 4;
   localparam int          CHANNELS      = 8;
   localparam int          WORD_WIDTH    = 10;
   localparam int          LOW_WIDTH     = 8;
   localparam int          HIGH_WIDTH    = 2;
   // prbs taps for x^10 + x^7 + 1
   localparam int          PRBS_TAP_A    = 9;
   localparam int          PRBS_TAP_B    = 6;
   // bus responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ---- hw/sensor_tp_regs.sv ----
/*
 * Test-pattern generator, black-calibration fault flags and their
 * interrupt, behind an AXI4-Lite register slave.
 * Assumes pixel and dark-sample inputs come from logic on clk, and that
 * the master keeps one write and one read outstanding at most.
 */
// How it works
// - each of channels 0..7 gets a fault flag when too few dark samples
// - pattern enable bit 0 replaces pixel data with generated words
// - bit 1 chooses incrementing pattern, else constant programmed value
// - bit 2 inserts a pseudo-random binary sequence into output data
// - bit 3 keeps frame and line structure, else words go unframed
// - lane 0 low eight bits from register 146 bits 7:0, reset 0x00
// - lane 1 low eight bits from register 146 bits 15:8, reset 0x01
// - lane 2 low eight bits from register 147 bits 7:0, reset 0x02
// - lane 3 low eight bits from register 147 bits 15:8, reset 0x03
// - high bits of every lane value come from register 150
// - fault register is read-only, resets to zero, ignores writes
// - register 150 holds two high bits per lane, lane 0 lowest
// - required dark samples equal two to the programmed count field
module sensor_tp_regs (
   input  wire logic                                  clk,
   input  wire logic                                  nrst,
   input  wire logic [sensor_tp_pkg::ADDR_WIDTH-1:0]  s_axi_awaddr,
   input  wire logic                                  s_axi_awvalid,
   output logic                                       s_axi_awready,
   input  wire logic [31:0]                           s_axi_wdata,
   input  wire logic [3:0]                            s_axi_wstrb,
   input  wire logic                                  s_axi_wvalid,
   output logic                                       s_axi_wready,
   output logic [1:0]                                 s_axi_bresp,
   output logic                                       s_axi_bvalid,
   input  wire logic                                  s_axi_bready,
   input  wire logic [sensor_tp_pkg::ADDR_WIDTH-1:0]  s_axi_araddr,
   input  wire logic                                  s_axi_arvalid,
   output logic                                       s_axi_arready,
   output logic [31:0]                                s_axi_rdata,
   output logic [1:0]                                 s_axi_rresp,
   output logic                                       s_axi_rvalid,
   input  wire logic                                  s_axi_rready,
   input  wire logic [3:0][9:0]                       pix_in,
   input  wire logic                                  pix_valid,
   input  wire logic                                  frame_valid_in,
   input  wire logic                                  line_valid_in,
   input  wire logic [7:0]                            dark_sample,
   input  wire logic                                  cal_end,
   output logic [3:0][9:0]                            pat_out,
   output logic                                       out_valid,
   output logic                                       frame_valid_out,
   output logic                                       line_valid_out,
   output logic [7:0]                                 cal_fault,
   output logic                                       irq
);
   typedef struct packed {
      logic            aw_held;
      logic [7:0]      aw_idx;
      logic            w_held;
      logic [15:0]     wdata;
      logic [1:0]      wstrb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [15:0]     rdata;
      logic [1:0]      rresp;
      logic [3:0]      ctrl;
      logic [15:0]     low01;
      logic [15:0]     low23;
      logic [7:0]      high;
      logic [2:0]      samples;
      logic [7:0]      fault;
      logic [7:0]      status;
      logic [7:0]      enable;
      logic [7:0][7:0] cnt;
      logic [3:0][9:0] lane;
      logic [9:0]      prbs;
      logic [3:0][9:0] dout;
      logic            dvalid;
      logic            fv;
      logic            lv;
   } state_type;

   state_type state;
   state_type next_state;
   logic      active;
   logic      emit;
   logic      wr_fire;
   logic [7:0] threshold;
   logic [7:0] clear_bits;
   logic [7:0] fault_events;

   // address decode shared by the read and write paths
   function automatic logic is_mapped(input logic [7:0] idx);
      case (idx)
         sensor_tp_pkg::IDX_FAULT, sensor_tp_pkg::IDX_RSV_A,
         sensor_tp_pkg::IDX_RSV_B, sensor_tp_pkg::IDX_RSV_C,
         sensor_tp_pkg::IDX_CFG_A, sensor_tp_pkg::IDX_CFG_B,
         sensor_tp_pkg::IDX_CTRL, sensor_tp_pkg::IDX_CFG_C,
         sensor_tp_pkg::IDX_LOW01, sensor_tp_pkg::IDX_LOW23,
         sensor_tp_pkg::IDX_CFG_D, sensor_tp_pkg::IDX_HIGH,
         sensor_tp_pkg::IDX_SAMPLES, sensor_tp_pkg::IDX_STATUS,
         sensor_tp_pkg::IDX_CLEAR, sensor_tp_pkg::IDX_ENABLE: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] data,
                                           input logic [1:0]  strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8],
                 strb[0] ? data[7:0]  : old[7:0]};
   endfunction

   function automatic logic [9:0] prog_value(input state_type s,
                                             input int        i);
      logic [7:0] low;
      logic [31:0] both;
      both = {s.low23, s.low01};
      low  = both[i*8 +: 8];
      prog_value = {s.high[i*2 +: 2], low};
   endfunction

   // register read mux; reserved words read their fixed values
   function automatic logic [15:0] read_value(input state_type  s,
                                              input logic [7:0] idx);
      case (idx)
         sensor_tp_pkg::IDX_FAULT:   read_value = {8'h00, s.fault};
         sensor_tp_pkg::IDX_CFG_B:   read_value = sensor_tp_pkg::CFG_B_VALUE;
         sensor_tp_pkg::IDX_CTRL:    read_value = {12'h000, s.ctrl};
         sensor_tp_pkg::IDX_LOW01:   read_value = s.low01;
         sensor_tp_pkg::IDX_LOW23:   read_value = s.low23;
         sensor_tp_pkg::IDX_CFG_D:   read_value = sensor_tp_pkg::CFG_D_VALUE;
         sensor_tp_pkg::IDX_HIGH:    read_value = {8'h00, s.high};
         sensor_tp_pkg::IDX_SAMPLES: read_value = {5'h00, s.samples, 8'h00};
         sensor_tp_pkg::IDX_STATUS:  read_value = {8'h00, s.status};
         sensor_tp_pkg::IDX_ENABLE:  read_value = {8'h00, s.enable};
         default:                    read_value = 16'h0000;
      endcase
   endfunction

   // handshake outputs straight from the held flags
   assign s_axi_awready   = !state.aw_held && !state.bvalid;
   assign s_axi_wready    = !state.w_held && !state.bvalid;
   assign s_axi_arready   = !state.rvalid;
   assign s_axi_bvalid    = state.bvalid;
   assign s_axi_bresp     = state.bresp;
   assign s_axi_rvalid    = state.rvalid;
   assign s_axi_rresp     = state.rresp;
   assign s_axi_rdata     = {16'h0000, state.rdata};
   assign pat_out         = state.dout;
   assign out_valid       = state.dvalid;
   assign frame_valid_out = state.fv;
   assign line_valid_out  = state.lv;
   assign cal_fault       = state.fault;
   assign irq             = |(state.status & state.enable);

   // substitution is on when either source is enabled
   assign active  = state.ctrl[sensor_tp_pkg::CTRL_TP_EN] ||
                    state.ctrl[sensor_tp_pkg::CTRL_PRBS];
   // framed words follow pixel timing, unframed ones run every cycle
   assign emit    = active && (!state.ctrl[sensor_tp_pkg::CTRL_FRAMED] ||
                               pix_valid);
   assign wr_fire = state.aw_held && state.w_held;
   // required count is two to the programmed field
   assign threshold = 8'h01 << state.samples;

   // flags that the pending write clears; hardware events still win
   assign clear_bits = (wr_fire && state.aw_idx == sensor_tp_pkg::IDX_CLEAR &&
                        state.wstrb[0]) ? state.wdata[7:0] : 8'h00;

   // a channel faults when its count falls short at window end
   generate
      for (genvar c = 0; c < sensor_tp_pkg::CHANNELS; c++) begin : g_ev
         assign fault_events[c] = cal_end && (state.cnt[c] < threshold);
      end
   endgenerate

   // next-state logic for bus, calibration and pattern generator
   always_comb begin
      next_state = state;
      // write address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_state.aw_held = 1'b1;
         next_state.aw_idx  = s_axi_awaddr[sensor_tp_pkg::IDX_LSB +: 8];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_state.w_held = 1'b1;
         next_state.wdata  = s_axi_wdata[15:0];
         next_state.wstrb  = s_axi_wstrb[1:0];
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = is_mapped(state.aw_idx) ?
                              sensor_tp_pkg::RESP_OKAY :
                              sensor_tp_pkg::RESP_SLVERR;
         // fault register has no write path
         case (state.aw_idx)
            sensor_tp_pkg::IDX_CTRL: begin
               next_state.ctrl = state.wstrb[0] ? state.wdata[3:0] :
                                 state.ctrl;
            end
            sensor_tp_pkg::IDX_LOW01: begin
               next_state.low01 = merge16(state.low01, state.wdata,
                                          state.wstrb);
            end
            sensor_tp_pkg::IDX_LOW23: begin
               next_state.low23 = merge16(state.low23, state.wdata,
                                          state.wstrb);
            end
            sensor_tp_pkg::IDX_HIGH: begin
               next_state.high = state.wstrb[0] ? state.wdata[7:0] :
                                 state.high;
            end
            sensor_tp_pkg::IDX_SAMPLES: begin
               next_state.samples = state.wstrb[1] ?
                  state.wdata[sensor_tp_pkg::SAMPLES_LSB +: 3] :
                  state.samples;
            end
            sensor_tp_pkg::IDX_ENABLE: begin
               next_state.enable = state.wstrb[0] ? state.wdata[7:0] :
                                   state.enable;
            end
            default: begin
               next_state.ctrl = state.ctrl;
            end
         endcase
      end
      // read answers one cycle after the address is taken
      if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_state.rvalid = 1'b1;
         next_state.rdata  = read_value(state,
                             s_axi_araddr[sensor_tp_pkg::IDX_LSB +: 8]);
         next_state.rresp  = is_mapped(
                             s_axi_araddr[sensor_tp_pkg::IDX_LSB +: 8]) ?
                             sensor_tp_pkg::RESP_OKAY :
                             sensor_tp_pkg::RESP_SLVERR;
      end
      // saturating counters, cleared when each window closes
      for (int c = 0; c < sensor_tp_pkg::CHANNELS; c++) begin
         if (cal_end) begin
            next_state.cnt[c] = 8'h00;
         end else if (dark_sample[c] && state.cnt[c] < 8'h80) begin
            next_state.cnt[c] = state.cnt[c] + 8'h01;
         end
      end
      // each window end rewrites the flags; sticky status for irq
      if (cal_end) begin
         next_state.fault = fault_events;
      end
      next_state.status = (state.status & ~clear_bits) | fault_events;
      // pattern datapath
      if (active) begin
         next_state.dvalid = emit;
         next_state.fv = state.ctrl[sensor_tp_pkg::CTRL_FRAMED] &&
                         frame_valid_in;
         next_state.lv = state.ctrl[sensor_tp_pkg::CTRL_FRAMED] &&
                         line_valid_in;
      end else begin
         next_state.dvalid = pix_valid;
         next_state.fv     = frame_valid_in;
         next_state.lv     = line_valid_in;
      end
      if (emit) begin
         // one ten-bit lfsr shared by all lanes
         next_state.prbs = {state.prbs[8:0],
                            state.prbs[sensor_tp_pkg::PRBS_TAP_A] ^
                            state.prbs[sensor_tp_pkg::PRBS_TAP_B]};
      end
      for (int i = 0; i < sensor_tp_pkg::LANES; i++) begin
         if (!active) begin
            next_state.dout[i] = pix_in[i];
            next_state.lane[i] = prog_value(state, i);
         end else if (!state.ctrl[sensor_tp_pkg::CTRL_INC]) begin
            // constant mode keeps the lane at its programmed value
            next_state.lane[i] = prog_value(state, i);
         end else if (emit) begin
            // add one per word, wrapping at ten bits
            next_state.lane[i] = state.lane[i] + 10'h001;
         end
         if (emit) begin
            if (state.ctrl[sensor_tp_pkg::CTRL_PRBS]) begin
               next_state.dout[i] = state.prbs;
            end else if (state.ctrl[sensor_tp_pkg::CTRL_INC]) begin
               next_state.dout[i] = state.lane[i];
            end else begin
               next_state.dout[i] = prog_value(state, i);
            end
         end
      end
   end

   // all state in one register; reset values overlay the zero fill
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state         <= '0;
         state.ctrl    <= sensor_tp_pkg::CTRL_RESET;
         state.low01   <= sensor_tp_pkg::LOW01_RESET;
         state.low23   <= sensor_tp_pkg::LOW23_RESET;
         state.high    <= sensor_tp_pkg::HIGH_RESET;
         state.fault   <= sensor_tp_pkg::FAULT_RESET;
         state.samples <= sensor_tp_pkg::SAMPLES_RESET;
         state.prbs    <= sensor_tp_pkg::PRBS_SEED;
      end else begin
         state <= next_state;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence wr_both;
      state.aw_held && state.w_held;
   endsequence

   AST_WRITE_RESP: assert property (wr_both |=> s_axi_bvalid)
      else $error("write response missing after address and data");
   AST_FAULT_RO: assert property (!cal_end |=> $stable(cal_fault))
      else $error("fault flags changed without a window end");
   AST_PRBS_WINS: assert property (
      emit && state.ctrl[sensor_tp_pkg::CTRL_PRBS] |=>
      pat_out[0] == $past(state.prbs) && pat_out[3] == $past(state.prbs))
      else $error("prbs word not on every lane");
   AST_UNFRAMED: assert property (
      active && !state.ctrl[sensor_tp_pkg::CTRL_FRAMED] |=>
      out_valid && !frame_valid_out && !line_valid_out)
      else $error("unframed pattern carries frame structure");
   AST_FRAMED: assert property (
      active && state.ctrl[sensor_tp_pkg::CTRL_FRAMED] |=>
      frame_valid_out == $past(frame_valid_in) &&
      out_valid == $past(pix_valid))
      else $error("framed pattern lost frame timing");
   AST_INC_STEP: assert property (
      emit && $past(emit) && state.ctrl == 4'h3 && $past(state.ctrl) == 4'h3
      |=> pat_out[1] == $past(pat_out[1]) + 10'h001)
      else $error("incrementing lane did not step by one");
   AST_IRQ_LEVEL: assert property (
      |(fault_events & state.enable) &&
      !(wr_fire && state.aw_idx == sensor_tp_pkg::IDX_ENABLE) |=> irq)
      else $error("enabled fault event did not raise irq");

   // per-channel fault and lane value checks
   generate
      for (genvar c = 0; c < sensor_tp_pkg::CHANNELS; c++) begin : g_chk
         AST_FAULT_SET: assert property (
            cal_end && state.cnt[c] < threshold |=> cal_fault[c] &&
            state.status[c])
            else $error("short dark count did not raise fault");
      end
      for (genvar i = 0; i < sensor_tp_pkg::LANES; i++) begin : g_lane
         AST_LANE_VALUE: assert property (
            emit && state.ctrl[2:1] == 2'h0 |=>
            pat_out[i] == $past(prog_value(state, i)))
            else $error("constant lane differs from programmed value");
      end
   endgenerate
endmodule

// ---- verif/tp_capture_model.sv ----
/*
 * capture receiver model: keeps the last two lane words it has taken.
 * assumes words are qualified by out_valid on the same clock.
 */
module tp_capture_model (
   input  wire logic            clk,
   input  wire logic            nrst,
   input  wire logic [3:0][9:0] word,
   input  wire logic            valid,
   output logic      [3:0][9:0] last,
   output logic      [3:0][9:0] prev
);
   timeunit 1ns;
   timeprecision 1ns;
   // no back-pressure on the lanes, so every qualified word is taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         last <= '0;
         prev <= '0;
      end else if (valid) begin
         prev <= last;
         last <= word;
      end
   end
endmodule

// ---- verif/test_sensor_tp_regs.sv ----
/*
 * self-checking bench for the pattern and calibration register bank.
 * assumes the axi4-lite slave, pattern lanes and fault inputs on one clk.
 */
module test_sensor_tp_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  clk = 1'b0, nrst = 1'b0;
   logic [9:0]            s_axi_awaddr, s_axi_araddr;
   logic [31:0]           s_axi_wdata, s_axi_rdata;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic                  s_axi_rready, pix_valid, frame_valid_in;
   logic                  line_valid_in, cal_end, out_valid, irq;
   logic                  frame_valid_out, line_valid_out;
   logic [3:0][9:0]       pix_in, pat_out, last, prev;
   logic [7:0]            dark_sample, cal_fault, hi;
   logic [15:0]           rd, l01, l23;
   integer                seed = 80;
   int                    errors = 0, checked = 0;
   logic [7:0]            rix [8] = '{8'h88, 8'h89, 8'h8d, 8'h90,
                                      8'h92, 8'h93, 8'h94, 8'h96};
   logic [15:0]           rval [8] = '{16'h0, 16'h0, 16'hffff, 16'h0,
                                       16'h0100, 16'h0302, 16'h0504, 16'h0};

   always #20 clk = ~clk;

   sensor_tp_regs sensor_tp_regs_inst (.clk, .nrst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_in,
      .pix_valid, .frame_valid_in, .line_valid_in, .dark_sample, .cal_end,
      .pat_out, .out_valid, .frame_valid_out, .line_valid_out, .cal_fault,
      .irq);
   tp_capture_model tp_capture_model_inst (.clk, .nrst, .word(pat_out),
      .valid(out_valid), .last, .prev);

   task end_of_test;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // both channels offered together, each dropped at its own handshake
   task wr(input logic [7:0] idx, input logic [15:0] d);
      int n;
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) begin
         errors++;
         end_of_test;
      end
   endtask

   task rdr(input logic [7:0] idx, output logic [15:0] d);
      int n;
      @(posedge clk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata[15:0];
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 40) begin
         errors++;
         end_of_test;
      end
   endtask

   // expected constant lane word: two high bits over the low byte
   function logic [9:0] lane_val(input int i);
      logic [15:0] w;
      w = (i < 2) ? l01 : l23;
      return {hi[2*i+1 -: 2], w[8*(i%2) +: 8]};
   endfunction

   function logic [9:0] prbs_step(input logic [9:0] w);
      return {w[8:0], w[9] ^ w[6]};
   endfunction

   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {pix_in, pix_valid, frame_valid_in, line_valid_in} = '0;
      {dark_sample, cal_end} = '0;
      s_axi_wstrb = 4'hf;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         rdr(rix[k], rd);
         chk("reset value", rval[k], rd);
         chk("read resp", sensor_tp_pkg::RESP_OKAY, rsp);
      end
      wr(8'h88, 16'hffff);
      rdr(8'h88, rd);
      chk("fault after write", 16'h0, rd);
      wr(8'h80, 16'h1234);
      chk("unmapped bresp", sensor_tp_pkg::RESP_SLVERR, rsp);
      rdr(8'h80, rd);
      chk("unmapped rresp", sensor_tp_pkg::RESP_SLVERR, rsp);
      // inactive generator passes sensor words through
      pix_in <= 40'({$random(seed), $random(seed)});
      {pix_valid, frame_valid_in, line_valid_in} <= 3'h7;
      cyc(3);
      chk("pass word", pix_in, pat_out);
      l01 = 16'($random(seed));
      l23 = 16'($random(seed));
      hi = 8'($random(seed));
      wr(8'h92, l01);
      wr(8'h93, l23);
      wr(8'h96, {8'h0, hi});
      wr(8'h90, 16'h0001);
      cyc(3);
      for (int i = 0; i < 4; i++)
         chk("const lane", lane_val(i), last[i]);
      chk("unframed fv", 1'b0, frame_valid_out);
      wr(8'h90, 16'h0009);
      cyc(2);
      chk("framed fv", 1'b1, frame_valid_out);
      {pix_valid, frame_valid_in, line_valid_in} <= 3'h0;
      cyc(3);
      chk("framed lv", 1'b0, line_valid_out);
      chk("framed valid", 1'b0, out_valid);
      pix_valid <= 1'b1;
      wr(8'h90, 16'h0003);
      cyc(3);
      // first counted word leaves one edge after the response
      for (int k = 0; k < 3; k++) begin
         cyc(1);
         for (int i = 0; i < 4; i++)
            chk("inc lane", 10'(lane_val(i) + k + 2), last[i]);
      end
      wr(8'h90, 16'h0007);
      cyc(3);
      repeat (3) begin
         cyc(1);
         chk("prbs step", prbs_step(prev[0]), last[0]);
         for (int i = 1; i < 4; i++)
            chk("prbs lanes", last[0], last[i]);
      end
      // prbs substitutes even without the synthesized pattern bit
      wr(8'h90, 16'h0004);
      cyc(3);
      chk("prbs alone", prbs_step(prev[0]), last[0]);
      // four samples needed: channels 7..4 get only three
      wr(8'h9b, 16'h0200);
      dark_sample <= 8'hff;
      cyc(3);
      dark_sample <= 8'h0f;
      cyc(1);
      dark_sample <= 8'h00;
      cal_end <= 1'b1;
      cyc(1);
      cal_end <= 1'b0;
      cyc(2);
      chk("cal fault", 8'hf0, cal_fault);
      rdr(8'h88, rd);
      chk("fault register", 16'h00f0, rd);
      chk("irq masked", 1'b0, irq);
      wr(8'h9e, 16'h00ff);
      cyc(1);
      chk("irq enabled", 1'b1, irq);
      wr(8'h9d, 16'h00ff);
      cyc(1);
      chk("irq cleared", 1'b0, irq);
      // empty window with the mask already open faults every channel
      cal_end <= 1'b1;
      cyc(1);
      cal_end <= 1'b0;
      cyc(1);
      chk("irq refault", 1'b1, irq);
      end_of_test;
   end
endmodule
